// *** design/pcsic_pkg.sv ***
// Shared constants and types for the program-flow and interrupt control block.
package pcsic_pkg;
   // ==========================================================================
   // Register indices; the Wishbone byte address is four times the index.
   localparam logic [4:0] IDX_PCL = 5'h02;
   localparam logic [4:0] IDX_LATCH = 5'h03;
   localparam logic [4:0] IDX_CPU_STATUS_REG = 5'h06;
   localparam logic [4:0] IDX_CORE_IRQ_FLAGS_ENABLES = 5'h07;
   localparam logic [4:0] IDX_TPL = 5'h0D;
   localparam logic [4:0] IDX_TPH = 5'h0E;
   localparam logic [4:0] IDX_PIR = 5'h16;
   localparam logic [4:0] IDX_PIE = 5'h17;
   localparam int ADR_W = 7;
   localparam int IDX_LSB = 2;

   // ==========================================================================
   // Field positions.
   localparam int ST_AVL_BIT = 5;
   localparam int ST_GID_BIT = 4;
   localparam int IS_MERGED_PERIPHERAL_REQUEST_BIT = 7;
   localparam int IS_PIN2_IR_BIT = 6;
   localparam int IS_OVF_IR_BIT = 5;
   localparam int IS_EDGE_IR_BIT = 4;
   localparam int IS_PERIPHERAL_GROUP_ENABLE_BIT = 3;
   localparam int IS_PIN2_IE_BIT = 2;
   localparam int IS_OVF_IE_BIT = 1;
   localparam int IS_EDGE_IE_BIT = 0;
   localparam int PIR_LIVE_W = 2;
   localparam int LONG_W = 8;
   localparam int JUMP_W = 13;

   // ==========================================================================
   // Vectors and reset values.
   localparam logic [15:0] VEC_EDGE = 16'h0008;
   localparam logic [15:0] VEC_OVF = 16'h0010;
   localparam logic [15:0] VEC_PIN2 = 16'h0018;
   localparam logic [15:0] VEC_PERIPH = 16'h0020;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam logic [15:0] PC_ONE = 16'h0001;
   localparam logic [15:0] PC_TWO = 16'h0002;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic GID_RST = 1'b1;

   // ==========================================================================
   // Commands from the execute stage, one per instruction cycle.
   typedef enum logic [2:0] {
      OP_NONE,
      OP_SKIP,
      OP_GOTO,
      OP_CALL,
      OP_LONG_CALL_OP,
      OP_RETURN,
      OP_RETURN_WITH_LITERAL_OP,
      OP_RETURN_FROM_IRQ_OP
   } pcsic_op_e;
endpackage

// *** design/pcsic_stack.sv ***
// Sixteen-deep circular return stack with availability tracking.
`timescale 1ns/1ps
`default_nettype none
module pcsic_stack #(
   parameter int DEPTH = 16,
   parameter int WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [WIDTH-1:0] push_dat_i,
   output logic [WIDTH-1:0] top_o,
   output logic avail_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);
   localparam logic [CW-1:0] CNT_ONE = CW'(1);
   localparam logic [PW-1:0] PTR_ONE = PW'(1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [CW-1:0] cnt_q;
   logic lost_q;
   logic under_q;
   logic full;
   logic empty;

   assign full = (cnt_q == FULL);
   assign empty = (cnt_q == '0);
   // The pointer wraps, so a push onto a full stack overwrites the oldest word.
   assign top_o = mem_q[wp_q - PTR_ONE];
   assign avail_o = !lost_q && !full; // RQ10

   // ==========================================================================
   // Storage and pointer; DEPTH must be a power of two for the wrap to work.
   always_ff @(posedge clk_i)
   begin
      if (push_i)
      begin
         mem_q[wp_q] <= push_dat_i; // RQ9
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         wp_q <= '0;
      else if (push_i)
         wp_q <= wp_q + PTR_ONE;
      else if (pop_i)
         wp_q <= wp_q - PTR_ONE;
   end

   // Fill level saturates at both ends.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         cnt_q <= '0;
      else if (push_i && !full)
         cnt_q <= cnt_q + CNT_ONE;
      else if (pop_i && !push_i && !empty)
         cnt_q <= cnt_q - CNT_ONE; // RQ11
   end

   // Overflow and the pop-then-push hazard are only forgotten at reset.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         lost_q <= 1'b0;
      else if (push_i && (full || under_q))
         lost_q <= 1'b1; // RQ12 RQ13
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         under_q <= 1'b0;
      else if (push_i)
         under_q <= 1'b0;
      else if (pop_i && empty)
         under_q <= 1'b1; // RQ13
   end

   // ==========================================================================
   // Checks.
   property p_full_clears;
      @(posedge clk_i) disable iff (rst_i) full |-> !avail_o;
   endproperty
   a_full_clears: assert property (p_full_clears) else $error("full stack shows available"); // RQ10

   property p_pop_restores;
      @(posedge clk_i) disable iff (rst_i) (full && !lost_q && pop_i && !push_i) |=> avail_o;
   endproperty
   a_pop_restores: assert property (p_pop_restores) else $error("pop from full did not restore"); // RQ11

   property p_overflow_sticks;
      @(posedge clk_i) disable iff (rst_i) (push_i && full) |=> !avail_o [*8];
   endproperty
   a_overflow_sticks: assert property (p_overflow_sticks) else $error("overflow not sticky"); // RQ12

   property p_underflow_push;
      @(posedge clk_i) disable iff (rst_i) (pop_i && empty && !push_i) ##[1:5] push_i |=> !avail_o;
   endproperty
   a_underflow_push: assert property (p_underflow_push) else $error("pop-empty then push kept flag"); // RQ13
endmodule // pcsic_stack
`default_nettype wire

// *** design/pcsic_core.sv ***
// Program counter, holding latch, table latch and interrupt vectoring unit.
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: Counter increments per fetch step; branches, writes, interrupts override; skip adds two.
// RQ2: Low byte lives at index 02h; high byte only via latch at 03h.
// RQ3: Long call loads high byte from latch, low byte from instruction.
// RQ4: Call and goto load bits 12..0, copy bits 15..13 to latch 7..5.
// RQ5: Reading the low byte copies the high byte into the latch.
// RQ6: Writing the low byte loads high byte from the latch: a jump.
// RQ7: Read-modify-write on low byte jumps without refreshing the latch.
// RQ8: Latch untouched by long call, returns, vectoring, read-modify-write.
// RQ9: Sixteen-word return stack; push on calls and interrupts, pop on returns.
// RQ10: Stack-available flag is set by reset, clear at sixteen entries.
// RQ11: Popping a full stack sets the flag again.
// RQ12: Pushing a full stack loses oldest entry, flag cleared until reset.
// RQ13: Pop on empty then push also clears the flag until reset.
// RQ14: Eleven request sources map onto four vectors.
// RQ15: Priority: edge pin 0008h, overflow 0010h, second pin 0018h, peripherals.
// RQ16: Response pushes the counter and loads the source's vector.
// RQ17: A lone request reaches its vector within three instruction cycles.
// RQ18: Hardware clears pin and overflow flags; software clears peripheral flags.
// RQ19: Response sets global disable; software clears flag then disable to nest.
// RQ20: Interrupt ending a long table write clears its flag as usual.
// RQ21: Peripherals share 0020h, own enables, group enable, summary bit 7.
// RQ22: Peripheral bit map: port B, timers 3..1, captures, serial tx, rx.
// RQ23: Unmapped sixteen-bit table latch holds words between memories.
// RQ24: Two pointer registers give the program address for table transfers.
// RQ25: A source is taken only with flag, enable and global enable.
module pcsic_core #(
   parameter int STACK_DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [pcsic_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic step_i,
   input wire pcsic_pkg::pcsic_op_e op_i,
   input wire logic [15:0] ir_i,
   input wire logic pcl_rmw_i,
   input wire logic edge_pin_i,
   input wire logic second_edge_pin_i,
   input wire logic counter_overflow_i,
   input wire logic [5:0] periph_set_i,
   input wire logic serial_tx_empty_flag_i,
   input wire logic serial_rx_full_flag_i,
   input wire logic long_write_i,
   input wire logic tbl_wr_i,
   input wire logic tbl_hi_i,
   input wire logic [7:0] tbl_dat_i,
   input wire logic tbl_load_i,
   input wire logic [15:0] prog_dat_i,
   output logic [15:0] pc_o,
   output logic irq_taken_o,
   output logic long_write_done_o,
   output logic [15:0] table_transfer_latch_o,
   output logic [15:0] table_addr_o,
   output logic stack_available_flag_o
);
   import pcsic_pkg::*;

   logic [15:0] pc_q;
   logic [7:0] latch_q;
   logic [15:0] tlat_q;
   logic [15:0] tptr_q;
   logic [7:0] pie_q;
   logic [5:0] pir_q;
   logic [3:0] ie_q;
   logic edge_ir_q;
   logic ovf_ir_q;
   logic pin2_ir_q;
   logic gid_q;
   logic ack_q;
   logic [7:0] rdat_q;
   logic irq_q;
   logic lwd_q;
   logic [7:0] rdat_d;
   logic [7:0] pir_full;
   logic [15:0] vec_d;
   logic [15:0] stk_top;
   logic stk_avail;
   logic req;
   logic wr_go;
   logic rd_go;
   logic [4:0] idx;
   logic take_edge;
   logic take_ovf;
   logic take_pin2;
   logic take_per;
   logic pend;
   logic irq_go;
   logic sel_edge;
   logic sel_ovf;
   logic sel_pin2;
   logic op_go;
   logic push;
   logic pop;
   logic [1:0] pin_raw;
   logic [1:0] s1_q;
   logic [1:0] s2_q;
   logic [1:0] s3_q;
   logic [1:0] filt_q;
   logic [1:0] edge_ev;

   // True when a bus write hits the given register index.
   function automatic logic wr_hit(input logic [4:0] i);
      return wr_go && (idx == i);
   endfunction

   // ==========================================================================
   // Wishbone slave: ack one cycle after the strobe, side effects at the ack edge.
   assign req = wb_cyc_i && wb_stb_i;
   assign idx = wb_adr_i[ADR_W-1:IDX_LSB];
   assign wr_go = req && wb_we_i && ack_q && wb_sel_i[0];
   assign rd_go = req && !wb_we_i && ack_q;
   assign wb_ack_o = ack_q;
   assign wb_dat_o = {24'h000000, rdat_q};

   // Ack drops the cycle after it was given, so back-to-back cycles see a gap.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= req && !ack_q;
   end

   // Read data is captured in the first cycle and held for the ack cycle.
   always_comb
   begin
      rdat_d = BYTE_RST;
      case (idx)
         IDX_PCL: rdat_d = pc_q[7:0]; // RQ2
         IDX_LATCH: rdat_d = latch_q;
         IDX_CPU_STATUS_REG:
         begin
            rdat_d[ST_AVL_BIT] = stk_avail;
            rdat_d[ST_GID_BIT] = gid_q;
         end
         IDX_CORE_IRQ_FLAGS_ENABLES: rdat_d = {|pir_full, pin2_ir_q, ovf_ir_q, edge_ir_q, ie_q}; // RQ21
         IDX_TPL: rdat_d = tptr_q[7:0];
         IDX_TPH: rdat_d = tptr_q[15:8];
         IDX_PIR: rdat_d = pir_full;
         IDX_PIE: rdat_d = pie_q;
         default: rdat_d = BYTE_RST;
      endcase
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rdat_q <= BYTE_RST;
      else if (req && !ack_q && !wb_we_i)
         rdat_q <= rdat_d;
   end

   // ==========================================================================
   // Pin synchronisers; a level counts once the second and third stages agree.
   assign pin_raw = {second_edge_pin_i, edge_pin_i};

   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_sync
         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               s1_q[g] <= 1'b0;
               s2_q[g] <= 1'b0;
               s3_q[g] <= 1'b0;
               filt_q[g] <= 1'b0;
            end
            else
            begin
               s1_q[g] <= pin_raw[g];
               s2_q[g] <= s1_q[g];
               s3_q[g] <= s2_q[g];
               if (s2_q[g] == s3_q[g])
                  filt_q[g] <= s3_q[g];
            end
         end
         // Both rising and falling edges raise a request.
         assign edge_ev[g] = (s2_q[g] == s3_q[g]) && (s3_q[g] != filt_q[g]);
      end
   endgenerate

   // ==========================================================================
   // Source selection and priority among the four vectors.
   assign pir_full = {pir_q, serial_tx_empty_flag_i, serial_rx_full_flag_i}; // RQ22
   assign take_edge = edge_ir_q && ie_q[IS_EDGE_IE_BIT]; // RQ25
   assign take_ovf = ovf_ir_q && ie_q[IS_OVF_IE_BIT];
   assign take_pin2 = pin2_ir_q && ie_q[IS_PIN2_IE_BIT];
   assign take_per = (|(pir_full & pie_q)) && ie_q[IS_PERIPHERAL_GROUP_ENABLE_BIT]; // RQ21 RQ25
   assign pend = take_edge || take_ovf || take_pin2 || take_per; // RQ14
   // A pending request is taken at the next instruction step, so latency is one cycle.
   assign irq_go = step_i && pend && !gid_q; // RQ17 RQ25
   assign sel_edge = take_edge; // RQ15
   assign sel_ovf = !take_edge && take_ovf;
   assign sel_pin2 = !take_edge && !take_ovf && take_pin2;

   always_comb
   begin
      if (sel_edge)
         vec_d = VEC_EDGE; // RQ15
      else if (sel_ovf)
         vec_d = VEC_OVF;
      else if (sel_pin2)
         vec_d = VEC_PIN2;
      else
         vec_d = VEC_PERIPH; // RQ21
   end

   // An interrupt or a bus write to the low byte preempts the decoder's command.
   assign op_go = step_i && !irq_go && !wr_hit(IDX_PCL);
   assign push = irq_go || (op_go && (op_i == OP_CALL || op_i == OP_LONG_CALL_OP)); // RQ9 RQ16
   assign pop = op_go && (op_i == OP_RETURN || op_i == OP_RETURN_WITH_LITERAL_OP || op_i == OP_RETURN_FROM_IRQ_OP); // RQ9

   // ==========================================================================
   // Program counter.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pc_q <= PC_RST;
      else if (irq_go)
         pc_q <= vec_d; // RQ16
      else if (wr_hit(IDX_PCL))
         pc_q <= {latch_q, wb_dat_i[7:0]}; // RQ6 RQ7
      else if (op_go)
      begin
         case (op_i)
            OP_SKIP: pc_q <= pc_q + PC_TWO; // RQ1
            OP_GOTO, OP_CALL: pc_q <= {pc_q[15:JUMP_W], ir_i[JUMP_W-1:0]}; // RQ4
            OP_LONG_CALL_OP: pc_q <= {latch_q, ir_i[LONG_W-1:0]}; // RQ3
            OP_RETURN, OP_RETURN_WITH_LITERAL_OP, OP_RETURN_FROM_IRQ_OP: pc_q <= stk_top; // RQ9
            default: pc_q <= pc_q + PC_ONE; // RQ1
         endcase
      end
   end

   // Holding latch: only software writes, low-byte reads and call/goto touch it.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         latch_q <= BYTE_RST;
      else if (wr_hit(IDX_LATCH))
         latch_q <= wb_dat_i[7:0];
      else if (rd_go && idx == IDX_PCL && !pcl_rmw_i)
         latch_q <= pc_q[15:8]; // RQ5 RQ7
      else if (op_go && (op_i == OP_GOTO || op_i == OP_CALL))
         latch_q[7:JUMP_W-8] <= pc_q[15:JUMP_W]; // RQ4 RQ8
   end

   // ==========================================================================
   // Core flags: hardware set wins over any clear in the same cycle.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         edge_ir_q <= 1'b0;
      else if (edge_ev[0])
         edge_ir_q <= 1'b1;
      else if (irq_go && sel_edge)
         edge_ir_q <= 1'b0; // RQ18 RQ20
      else if (wr_hit(IDX_CORE_IRQ_FLAGS_ENABLES))
         edge_ir_q <= wb_dat_i[IS_EDGE_IR_BIT];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ovf_ir_q <= 1'b0;
      else if (counter_overflow_i)
         ovf_ir_q <= 1'b1;
      else if (irq_go && sel_ovf)
         ovf_ir_q <= 1'b0; // RQ18 RQ20
      else if (wr_hit(IDX_CORE_IRQ_FLAGS_ENABLES))
         ovf_ir_q <= wb_dat_i[IS_OVF_IR_BIT];
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pin2_ir_q <= 1'b0;
      else if (edge_ev[1])
         pin2_ir_q <= 1'b1;
      else if (irq_go && sel_pin2)
         pin2_ir_q <= 1'b0; // RQ18 RQ20
      else if (wr_hit(IDX_CORE_IRQ_FLAGS_ENABLES))
         pin2_ir_q <= wb_dat_i[IS_PIN2_IR_BIT];
   end

   // Enables of the core sources and the peripheral group.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ie_q <= '0;
      else if (wr_hit(IDX_CORE_IRQ_FLAGS_ENABLES))
         ie_q <= wb_dat_i[IS_PERIPHERAL_GROUP_ENABLE_BIT:IS_EDGE_IE_BIT];
   end

   // Peripheral flags are never cleared by the response; software owns them.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pir_q <= '0;
      else if (wr_hit(IDX_PIR))
         pir_q <= periph_set_i | wb_dat_i[7:PIR_LIVE_W]; // RQ18
      else
         pir_q <= pir_q | periph_set_i; // RQ22
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         pie_q <= BYTE_RST;
      else if (wr_hit(IDX_PIE))
         pie_q <= wb_dat_i[7:0];
   end

   // Global disable: set by every response, released by software or a return-from-interrupt.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         gid_q <= GID_RST;
      else if (irq_go)
         gid_q <= 1'b1; // RQ19
      else if (wr_hit(IDX_CPU_STATUS_REG))
         gid_q <= wb_dat_i[ST_GID_BIT];
      else if (op_go && op_i == OP_RETURN_FROM_IRQ_OP)
         gid_q <= 1'b0;
   end

   // Response pulses to the decoder, which must discard the preempted instruction.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         irq_q <= 1'b0;
         lwd_q <= 1'b0;
      end
      else
      begin
         irq_q <= irq_go;
         lwd_q <= irq_go && long_write_i; // RQ20
      end
   end

   // ==========================================================================
   // Table transfer latch and program-memory pointer.
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tlat_q <= PC_RST;
      else if (tbl_load_i)
         tlat_q <= prog_dat_i; // RQ23
      else if (tbl_wr_i && tbl_hi_i)
         tlat_q[15:8] <= tbl_dat_i;
      else if (tbl_wr_i)
         tlat_q[7:0] <= tbl_dat_i; // RQ23
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tptr_q <= PC_RST;
      else if (wr_hit(IDX_TPL))
         tptr_q[7:0] <= wb_dat_i[7:0]; // RQ24
      else if (wr_hit(IDX_TPH))
         tptr_q[15:8] <= wb_dat_i[7:0]; // RQ24
   end

   pcsic_stack #(
      .DEPTH(STACK_DEPTH),
      .WIDTH(16)
   ) u_stack (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .push_i(push),
      .pop_i(pop),
      .push_dat_i(pc_q),
      .top_o(stk_top),
      .avail_o(stk_avail)
   );

   assign pc_o = pc_q;
   assign irq_taken_o = irq_q;
   assign long_write_done_o = lwd_q;
   assign table_transfer_latch_o = tlat_q;
   assign table_addr_o = tptr_q;
   assign stack_available_flag_o = stk_avail;

   // ==========================================================================
   // Checks.
   property p_inc;
      @(posedge clk_i) disable iff (rst_i) (op_go && op_i == OP_NONE) |=> pc_q == $past(pc_q) + PC_ONE;
   endproperty
   a_inc: assert property (p_inc) else $error("counter did not increment"); // RQ1

   property p_long_call_op;
      @(posedge clk_i) disable iff (rst_i)
         (op_go && op_i == OP_LONG_CALL_OP && !wr_go && !rd_go) |=> (pc_q == {$past(latch_q), $past(ir_i[7:0])}) && $stable(latch_q);
   endproperty
   a_long_call_op: assert property (p_long_call_op) else $error("long call target wrong"); // RQ3

   property p_goto;
      @(posedge clk_i) disable iff (rst_i)
         (op_go && op_i == OP_GOTO && !wr_go && !rd_go) |=> latch_q[7:5] == $past(pc_q[15:13]);
   endproperty
   a_goto: assert property (p_goto) else $error("latch not updated by goto"); // RQ4

   property p_read_copy;
      @(posedge clk_i) disable iff (rst_i) (rd_go && idx == IDX_PCL && !pcl_rmw_i) |=> latch_q == $past(pc_q[15:8]);
   endproperty
   a_read_copy: assert property (p_read_copy) else $error("read did not copy high byte"); // RQ5

   property p_write_jump;
      @(posedge clk_i) disable iff (rst_i)
         (wr_hit(IDX_PCL) && !irq_go) |=> pc_q == {$past(latch_q), $past(wb_dat_i[7:0])};
   endproperty
   a_write_jump: assert property (p_write_jump) else $error("low byte write jump wrong"); // RQ6

   property p_rmw;
      @(posedge clk_i) disable iff (rst_i) (rd_go && idx == IDX_PCL && pcl_rmw_i) |=> $stable(latch_q);
   endproperty
   a_rmw: assert property (p_rmw) else $error("rmw read changed latch"); // RQ7

   property p_vector;
      @(posedge clk_i) disable iff (rst_i) (irq_go && sel_ovf) |=> (pc_q == VEC_OVF) && gid_q && irq_taken_o;
   endproperty
   a_vector: assert property (p_vector) else $error("overflow vector wrong"); // RQ15 RQ16 RQ19

   property p_latency;
      @(posedge clk_i) disable iff (rst_i) (pend && !gid_q && step_i) |=> irq_taken_o && (pc_q == $past(vec_d));
   endproperty
   a_latency: assert property (p_latency) else $error("interrupt not taken in time"); // RQ17

   property p_hw_clear;
      @(posedge clk_i) disable iff (rst_i) (irq_go && sel_edge && !edge_ev[0]) |=> !edge_ir_q;
   endproperty
   a_hw_clear: assert property (p_hw_clear) else $error("edge flag not cleared"); // RQ18
endmodule // pcsic_core
`default_nettype wire

// *** bench/pcsic_exec_model.sv ***
// Behavioural execute stage that issues one command per instruction step.
`timescale 1ns/1ps
`default_nettype none
module pcsic_exec_model
   import pcsic_pkg::*;
(
   input wire logic clk_i,
   output logic step_o,
   output var pcsic_pkg::pcsic_op_e op_o,
   output logic [15:0] ir_o
);
   // Idle from time zero so no step is seen during reset.
   initial
   begin
      step_o = 1'b0;
      op_o = OP_NONE;
      ir_o = 16'h0000;
   end

   // One-cycle step; the command is held until the taking edge.
   task automatic issue(input pcsic_op_e o, input logic [15:0] i);
      @(posedge clk_i);
      step_o <= 1'b1;
      op_o <= o;
      ir_o <= i;
      @(posedge clk_i);
      step_o <= 1'b0;
      op_o <= OP_NONE;
   endtask
endmodule // pcsic_exec_model
`default_nettype wire

// *** bench/test_pc_stack_irq_control.sv ***
// Self-checking bench for the program-flow and interrupt control block.
`timescale 1ns/1ps
`default_nettype none
module test_pc_stack_irq_control;
   import pcsic_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ack, rm, lw, rx, tx, tw, th, tl, ep, sp, ov, step, irq, lwd, avl;
   logic [6:0] adr;
   logic [31:0] wd, rd;
   logic [5:0] ps;
   logic [7:0] td, r;
   logic [15:0] pd, pc, tlat, tadr, ir;
   pcsic_op_e op;
   logic [15:0] vec [4] = '{VEC_EDGE, VEC_OVF, VEC_PIN2, VEC_PERIPH};
   int errors, checks_done, k;

   // ==========================================================
   // Clock, design and execute-stage model.
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   pcsic_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .step_i(step),
      .op_i(op), .ir_i(ir), .pcl_rmw_i(rm), .edge_pin_i(ep), .second_edge_pin_i(sp),
      .counter_overflow_i(ov), .periph_set_i(ps), .serial_tx_empty_flag_i(tx),
      .serial_rx_full_flag_i(rx), .long_write_i(lw), .tbl_wr_i(tw), .tbl_hi_i(th), .tbl_dat_i(td),
      .tbl_load_i(tl), .prog_dat_i(pd), .pc_o(pc), .irq_taken_o(irq), .long_write_done_o(lwd),
      .table_transfer_latch_o(tlat), .table_addr_o(tadr), .stack_available_flag_o(avl));
   pcsic_exec_model m (.clk_i(clk_i), .step_o(step), .op_o(op), .ir_o(ir));

   // ==========================================================
   // Shared tasks.
   task automatic chk(input logic [15:0] s, input logic [15:0] e, input string n);
      checks_done++;
      if (s !== e)
      begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   // Classic cycle; held until ack is sampled, released at that edge.
   task automatic bus(input logic w, input logic [4:0] i, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      wd <= {24'h000000, d};
      @(posedge clk_i);
      while (ack !== 1'b1)
         @(posedge clk_i);
      r = rd[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // The delay lets the counter update of the taking edge settle.
   task automatic st(input pcsic_op_e o, input logic [15:0] i);
      m.issue(o, i);
      #1;
   endtask
   task automatic rst;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_pc;
      st(OP_NONE, 16'h0000);
      chk(pc, 16'h0001, "pc");
      st(OP_SKIP, 16'h0000);
      chk(pc, 16'h0003, "pc");
      bus(1'b1, IDX_LATCH, 8'hE1);
      st(OP_LONG_CALL_OP, 16'h0077);
      chk(pc, 16'hE177, "pc");
      bus(1'b0, IDX_LATCH, 8'h00);
      chk(r, 8'hE1, "latch");
      bus(1'b1, IDX_LATCH, 8'h00);
      bus(1'b0, IDX_PCL, 8'h00);
      chk(r, 8'h77, "pcl");
      bus(1'b0, IDX_LATCH, 8'h00);
      chk(r, 8'hE1, "latch");
      bus(1'b1, IDX_LATCH, 8'h00);
      st(OP_CALL, 16'h0033);
      chk(pc, 16'hE033, "pc");
      bus(1'b0, IDX_LATCH, 8'h00);
      chk(r, 8'hE0, "latch");
      st(OP_RETURN, 16'h0000);
      chk(pc, 16'hE177, "pc");
      st(OP_RETURN_WITH_LITERAL_OP, 16'h0000);
      chk(pc, 16'h0003, "pc");
      bus(1'b1, IDX_LATCH, 8'h12);
      rm <= 1'b1;
      bus(1'b0, IDX_PCL, 8'h00);
      rm <= 1'b0;
      bus(1'b0, IDX_LATCH, 8'h00);
      chk(r, 8'h12, "latch");
      bus(1'b1, IDX_PCL, 8'h20);
      #1;
      chk(pc, 16'h1220, "pc");
      st(OP_GOTO, 16'hFFFF);
      chk(pc, 16'h1FFF, "pc");
      $display("test pc done");
   endtask
   task automatic t_stack;
      for (k = 1; k <= 16; k++)
      begin
         st(OP_CALL, 16'h0000);
         chk(avl, k < 16, "avail");
      end
      st(OP_RETURN, 16'h0000);
      chk(avl, 1'b1, "avail");
      st(OP_CALL, 16'h0000);
      st(OP_CALL, 16'h0000);
      st(OP_RETURN, 16'h0000);
      chk(avl, 1'b0, "avail");
      bus(1'b0, IDX_CPU_STATUS_REG, 8'h00);
      chk(r, 8'h10, "cpu_status_reg");
      rst;
      bus(1'b0, IDX_CPU_STATUS_REG, 8'h00);
      chk(r, 8'h30, "cpu_status_reg");
      st(OP_RETURN, 16'h0000);
      st(OP_CALL, 16'h0000);
      chk(avl, 1'b0, "avail");
      $display("test stack done");
   endtask
   // All four vectors pending at once are served in priority order.
   task automatic t_irq;
      bus(1'b1, IDX_CORE_IRQ_FLAGS_ENABLES, 8'h0F);
      bus(1'b1, IDX_PIE, 8'h04);
      ov <= 1'b1;
      ps <= 6'h01;
      ep <= 1'b1;
      sp <= 1'b1;
      @(posedge clk_i);
      ov <= 1'b0;
      ps <= 6'h00;
      repeat (6) @(posedge clk_i);
      st(OP_NONE, 16'h0000);
      chk(pc, 16'h0001, "pc");
      bus(1'b0, IDX_CORE_IRQ_FLAGS_ENABLES, 8'h00);
      chk(r, 8'hFF, "core_irq_flags_enables");
      for (k = 0; k < 4; k++)
      begin
         bus(1'b1, IDX_CPU_STATUS_REG, 8'h00);
         lw <= (k == 0);
         st(OP_NONE, 16'h0000);
         chk(pc, vec[k], "vector");
         chk(irq, 1'b1, "taken");
         chk(lwd, k == 0, "longdone");
      end
      bus(1'b0, IDX_CORE_IRQ_FLAGS_ENABLES, 8'h00);
      chk(r, 8'h8F, "core_irq_flags_enables");
      bus(1'b0, IDX_CPU_STATUS_REG, 8'h00);
      chk(r, 8'h30, "cpu_status_reg");
      st(OP_RETURN_FROM_IRQ_OP, 16'h0000);
      chk(pc, VEC_PIN2, "pc");
      bus(1'b1, IDX_PIR, 8'h00);
      rx <= 1'b1;
      tx <= 1'b1;
      bus(1'b0, IDX_PIR, 8'h00);
      chk(r, 8'h03, "pir");
      st(OP_NONE, 16'h0000);
      chk(pc, 16'h0019, "pc");
      $display("test irq done");
   endtask
   task automatic t_tbl;
      @(posedge clk_i);
      tl <= 1'b1;
      pd <= 16'hBEEF;
      @(posedge clk_i);
      tl <= 1'b0;
      tw <= 1'b1;
      th <= 1'b1;
      td <= 8'h12;
      @(posedge clk_i);
      tw <= 1'b0;
      #1;
      chk(tlat, 16'h12EF, "tlat");
      bus(1'b1, IDX_TPL, 8'h34);
      bus(1'b1, IDX_TPH, 8'h56);
      #1;
      chk(tadr, 16'h5634, "tptr");
      $display("test table done");
   endtask

   // ==========================================================
   // Main sequence; the watchdog ends a hang through the same task.
   initial
   begin
      {rst_i, cyc, stb, we, rm, lw, rx, tx, tw, th, tl, ep, sp, ov} = 14'h2000;
      {adr, wd, ps, td, pd} = '0;
      rst;
      t_pc;
      rst;
      t_stack;
      rst;
      t_irq;
      t_tbl;
      complete_run;
   end
   initial
   begin
      #100000;
      errors++;
      complete_run;
   end
endmodule // test_pc_stack_irq_control
`default_nettype wire
